/* hdl/ring_drive_end.sv */
/*
  drive (slave) end of the ring: phase tracking, phase-4 transition
  check, telegram validation, failure counting and shutdown control.
  assumes the master end drives the link strobes on the same clock and
  that a cycle-tick input marks each communication cycle boundary.
*/
`timescale 1ns/1ps
`include "ring_defs.svh"

module ring_drive_end
    import ring_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int DATA_W = 16,
    parameter int LIST_W = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link to the master
    ring_link_if.drive link,
    // local timing and parameter checker
    input wire logic cycle_tick,
    input wire logic params_valid,
    input wire logic [LIST_W-1:0] invalid_param_mask,
    // command values
    input wire logic [DATA_W-1:0] command_in,
    input wire logic command_in_stb,
    output logic [DATA_W-1:0] command_out,
    output logic command_substituted,
    // status
    output logic [2:0] phase,
    output logic power_enable,
    output logic shutdown_req,
    output logic comm_error,
    output logic [LIST_W-1:0] invalid_param_list,
    output logic [CNT_W-1:0] sync_miss_count,
    output logic [CNT_W-1:0] data_miss_count
);

    typedef struct packed {
        logic [2:0] phase;
        check_state_type check;
        logic [15:0] calc_cnt;
        logic [1:0] ack;
        logic [LIST_W-1:0] bad_list;
        logic sync_seen;
        logic data_seen;
        logic [1:0] sync_fails;
        logic [1:0] data_fails;
        logic [CNT_W-1:0] sync_total;
        logic [CNT_W-1:0] data_total;
        logic comm_err;
        logic shutdown;
        logic reply;
        logic [DATA_W-1:0] last_cmd;
        logic [DATA_W-1:0] cmd_out;
        logic subst;
    } drive_state_type;

    drive_state_type state_reg;
    drive_state_type state_next;
    logic sync_ok;
    logic data_ok;
    logic sync_double;
    logic data_double;

    // telegram quality judged from the four checks, plus phase range for sync
    assign sync_ok = link.sync_telegram_stb && link.sync_crc_ok &&
        link.sync_time_ok && link.sync_len_ok && link.sync_addr_ok &&
        (link.phase_byte_a <= `PHASE_MAX);
    assign data_ok = link.master_data_telegram_stb && link.data_crc_ok &&
        link.data_time_ok && link.data_len_ok &&
        link.data_addr_ok;
    // a cycle without a good telegram counts as a failure at its end
    assign sync_double = cycle_tick && !state_reg.sync_seen &&
        (state_reg.sync_fails == `FAIL_LIMIT - 2'h1);
    assign data_double = cycle_tick && !state_reg.data_seen &&
        (state_reg.data_fails == `FAIL_LIMIT - 2'h1);

    // next-state logic
    always_comb
    begin
        state_next = state_reg;
        state_next.reply = 1'b0;
        state_next.subst = 1'b0;
        if (sync_ok)
        begin
            state_next.sync_seen = 1'b1;
            state_next.phase = link.phase_byte_a;
        end
        if (data_ok)
        begin
            state_next.data_seen = 1'b1;
        end
        // cycle boundary: count misses, keep the cycle running anyway
        if (cycle_tick)
        begin
            state_next.sync_seen = sync_ok;
            state_next.data_seen = data_ok;
            if (state_reg.sync_seen)
            begin
                state_next.sync_fails = 2'h0;
            end
            else
            begin
                state_next.sync_total = state_reg.sync_total +
                    CNT_W'(1);
                if (state_reg.sync_fails != `FAIL_LIMIT)
                begin
                    state_next.sync_fails = state_reg.sync_fails + 2'h1;
                end
            end
            if (state_reg.data_seen)
            begin
                state_next.data_fails = 2'h0;
            end
            else
            begin
                state_next.data_total = state_reg.data_total +
                    CNT_W'(1);
                if (state_reg.data_fails != `FAIL_LIMIT)
                begin
                    state_next.data_fails = state_reg.data_fails + 2'h1;
                end
            end
        end
        // double sync failures in phase three or four, or double data failures in phase four, drop back to zero
        if (sync_double && (state_reg.phase == `PHASE_THREE ||
            state_reg.phase == `PHASE_FOUR))
        begin
            state_next.phase = `PHASE_ZERO;
            state_next.comm_err = 1'b1;
        end
        if (data_double && state_reg.phase == `PHASE_FOUR)
        begin
            state_next.phase = `PHASE_ZERO;
            state_next.comm_err = 1'b1;
        end
        // shutdown held outside phase four
        state_next.shutdown =
            (state_next.phase != `PHASE_FOUR);
        // reply only in a cycle whose sync telegram arrived
        if (cycle_tick && state_reg.sync_seen)
        begin
            state_next.reply = 1'b1;
        end
        // command values: last good, or substitute on a miss
        if (command_in_stb && data_ok)
        begin
            state_next.last_cmd = command_in;
            state_next.cmd_out = command_in;
        end
        else if (cycle_tick && !state_reg.data_seen)
        begin
            state_next.cmd_out = state_reg.last_cmd;
            state_next.subst = 1'b1;
        end
        // phase-four transition check procedure command
        case (state_reg.check)
            check_idle_type:
            begin
                state_next.ack = `ACK_IDLE;
                if (link.check_cmd && state_reg.phase == `PHASE_THREE)
                begin
                    state_next.check = check_calc_type;
                    state_next.calc_cnt = 16'h0000;
                    state_next.ack = `ACK_BUSY;
                end
            end
            check_calc_type:
            begin
                state_next.ack = `ACK_BUSY;
                state_next.calc_cnt = state_reg.calc_cnt + 16'h0001;
                if (state_reg.calc_cnt == `CALC_CLKS - 16'h0001)
                begin
                    state_next.check = check_report_type;
                    if (params_valid)
                    begin
                        state_next.ack = `ACK_DONE;
                    end
                    else
                    begin
                        state_next.ack = `ACK_ERROR;
                        state_next.bad_list = invalid_param_mask;
                    end
                end
            end
            check_report_type:
            begin
                // answer holds until the master clears the command
                if (!link.check_cmd)
                begin
                    state_next.check = check_idle_type;
                    state_next.ack = `ACK_IDLE;
                end
            end
            default:
            begin
                state_next.check = check_idle_type;
                state_next.ack = `ACK_IDLE;
            end
        endcase
        if (!link.check_cmd && state_reg.check == check_calc_type)
        begin
            state_next.check = check_idle_type;
            state_next.ack = `ACK_IDLE;
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '{phase: `PHASE_ZERO, check: check_idle_type,
                shutdown: 1'b1, default: '0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign phase = state_reg.phase;
    assign shutdown_req = state_reg.shutdown;
    assign power_enable = !state_reg.shutdown;
    assign comm_error = state_reg.comm_err;
    assign invalid_param_list = state_reg.bad_list;
    assign sync_miss_count = state_reg.sync_total;
    assign data_miss_count = state_reg.data_total;
    assign command_out = state_reg.cmd_out;
    assign command_substituted = state_reg.subst;
    assign link.check_ack = state_reg.ack;
    assign link.drive_reply_telegram_stb = state_reg.reply;

endmodule

/* hdl/ring_defs.svh */
/*
  timing counts, phase codes and acknowledgement codes for the ring
  phase and fault monitor. assumes nothing; definitions only.
*/
`ifndef RING_DEFS_SVH
`define RING_DEFS_SVH

`define PHASE_ZERO 3'h0
`define PHASE_THREE 3'h3
`define PHASE_FOUR 3'h4
`define PHASE_MAX 3'h4
`define FAIL_LIMIT 2'h2
`define CLK_HZ 25000000
`define CYCLE_US 1000
`define CYCLE_CLKS ((`CLK_HZ / 1000000) * `CYCLE_US)
`define ACK_IDLE 2'h0
`define ACK_BUSY 2'h1
`define ACK_DONE 2'h2
`define ACK_ERROR 2'h3
`define CALC_CLKS 16'h0010
`define MASTER_SWITCH_CYCLES 2'h1

`endif

/* hdl/ring_pkg.sv */
/*
  types shared by both ends of the ring phase and fault monitor.
  assumes ring_defs.svh is on the include path.
*/
package ring_pkg;
    typedef enum logic [1:0] {
        check_idle_type = 2'b00,
        check_calc_type = 2'b01,
        check_report_type = 2'b10
    } check_state_type;

    typedef enum logic [1:0] {
        mstate_run_type = 2'b00,
        mstate_gap_type = 2'b01,
        mstate_hold_type = 2'b10
    } master_state_type;
endpackage

/* hdl/ring_link_if.sv */
/*
  interface joining the drive end and the master end of the ring.
  assumes one clock shared by both ends; telegram events are one-cycle
  strobes carrying the judged quality of each telegram.
*/
`timescale 1ns/1ps

interface ring_link_if;
    logic sync_telegram_stb;
    logic [2:0] phase_byte_a;
    logic sync_crc_ok;
    logic sync_time_ok;
    logic sync_len_ok;
    logic sync_addr_ok;
    logic master_data_telegram_stb;
    logic data_crc_ok;
    logic data_time_ok;
    logic data_len_ok;
    logic data_addr_ok;
    logic check_cmd;
    logic [1:0] check_ack;
    logic drive_reply_telegram_stb;

    modport drive
    (
        input sync_telegram_stb, phase_byte_a, sync_crc_ok, sync_time_ok,
        input sync_len_ok, sync_addr_ok, master_data_telegram_stb,
        input data_crc_ok, data_time_ok, data_len_ok, data_addr_ok,
        input check_cmd,
        output check_ack, drive_reply_telegram_stb
    );

    modport master
    (
        output sync_telegram_stb, phase_byte_a, sync_crc_ok, sync_time_ok,
        output sync_len_ok, sync_addr_ok, master_data_telegram_stb,
        output data_crc_ok, data_time_ok, data_len_ok, data_addr_ok,
        output check_cmd,
        input check_ack, drive_reply_telegram_stb
    );
endinterface

/* hdl/ring_master_end.sv */
/*
  master end of the ring: cycle timer, sync and data telegram strobes,
  phase requests, transition check command and ring-open monitoring.
  assumes the drive end answers on the same clock.
*/
`timescale 1ns/1ps
`include "ring_defs.svh"

module ring_master_end
    import ring_pkg::*;
#(
    parameter int CYCLE_CLKS = `CYCLE_CLKS,
    parameter int CLOSE_RUN = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link to the drive
    ring_link_if.master link,
    // user requests
    input wire logic [2:0] phase_req,
    input wire logic check_start,
    input wire logic go_phase_zero,
    input wire logic inject_fault,
    // status
    output logic cycle_tick,
    output logic [2:0] phase,
    output logic ring_closed,
    output logic [1:0] check_result
);

    typedef struct packed {
        logic [15:0] tick_cnt;
        logic tick;
        master_state_type mode;
        logic [2:0] phase;
        logic [1:0] fails;
        logic [7:0] good_run;
        logic closed;
        logic reply_seen;
        logic check;
        logic [1:0] result;
        logic sync_stb;
        logic data_stb;
    } master_rec_type;

    master_rec_type state_reg;
    master_rec_type state_next;

    // cycle timer, sync at cycle start, data telegram two clocks later
    always_comb
    begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        state_next.sync_stb = 1'b0;
        state_next.data_stb = 1'b0;
        state_next.tick_cnt = state_reg.tick_cnt + 16'h0001;
        if (state_reg.tick_cnt == 16'(CYCLE_CLKS - 1))
        begin
            state_next.tick_cnt = 16'h0000;
            state_next.tick = 1'b1;
        end
        if (state_reg.tick_cnt == 16'h0001)
        begin
            // keep the grid during phase switching
            state_next.sync_stb = !inject_fault;
        end
        if (state_reg.tick_cnt == 16'h0003)
        begin
            state_next.data_stb = !inject_fault;
        end
        if (state_reg.tick)
        begin
            if (go_phase_zero && state_reg.phase >= `PHASE_THREE)
            begin
                state_next.phase = `PHASE_ZERO;
            end
            else if (state_reg.check == 1'b0 && !go_phase_zero)
            begin
                state_next.phase = phase_req;
            end
            // ring monitoring only in phase zero
            if (state_reg.phase == `PHASE_ZERO)
            begin
                if (state_reg.reply_seen)
                begin
                    state_next.fails = 2'h0;
                    if (state_reg.good_run != 8'(CLOSE_RUN))
                    begin
                        state_next.good_run = state_reg.good_run + 8'h01;
                    end
                    else
                    begin
                        state_next.closed = 1'b1;
                    end
                end
                else
                begin
                    state_next.good_run = 8'h00;
                    if (state_reg.fails != `FAIL_LIMIT)
                    begin
                        state_next.fails = state_reg.fails + 2'h1;
                    end
                    if (state_reg.fails == `FAIL_LIMIT - 2'h1)
                    begin
                        state_next.closed = 1'b0;
                    end
                end
            end
            state_next.reply_seen = 1'b0;
        end
        if (link.drive_reply_telegram_stb)
        begin
            state_next.reply_seen = 1'b1;
        end
        // check command held until answered, then cleared
        if (check_start && state_reg.phase == `PHASE_THREE)
        begin
            state_next.check = 1'b1;
        end
        if (state_reg.check && (link.check_ack == `ACK_DONE ||
            link.check_ack == `ACK_ERROR))
        begin
            state_next.check = 1'b0;
            state_next.result = link.check_ack;
        end
        state_next.mode = mstate_run_type;
    end

    // state register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '{mode: mstate_run_type, default: '0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // link drive: phase byte carries current phase, checks all good
    assign link.sync_telegram_stb = state_reg.sync_stb;
    assign link.phase_byte_a = state_reg.phase;
    assign link.sync_crc_ok = 1'b1;
    assign link.sync_time_ok = 1'b1;
    assign link.sync_len_ok = 1'b1;
    assign link.sync_addr_ok = 1'b1;
    assign link.master_data_telegram_stb = state_reg.data_stb;
    assign link.data_crc_ok = 1'b1;
    assign link.data_time_ok = 1'b1;
    assign link.data_len_ok = 1'b1;
    assign link.data_addr_ok = 1'b1;
    assign link.check_cmd = state_reg.check;
    assign cycle_tick = state_reg.tick;
    assign phase = state_reg.phase;
    assign ring_closed = state_reg.closed;
    assign check_result = state_reg.result;

endmodule

/* bench/ring_link_properties.sv */
/*
  concurrent checks on the link between the master end and drive end.
  assumes one clock; inputs are link signals plus the master cycle tick.
*/
`timescale 1ns/1ps
`include "ring_defs.svh"

module ring_link_properties
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link signals
    input wire logic cycle_tick,
    input wire logic sync_telegram_stb,
    input wire logic [2:0] phase_byte_a,
    input wire logic sync_crc_ok,
    input wire logic sync_time_ok,
    input wire logic sync_len_ok,
    input wire logic sync_addr_ok,
    input wire logic check_cmd,
    input wire logic [1:0] check_ack,
    input wire logic drive_reply_telegram_stb
);
    logic [4:0] busy_reg;
    logic seen_reg;
    logic had_reg;
    logic sync_ok;

    // a sync telegram counts only with every qualifier good
    assign sync_ok = sync_telegram_stb && sync_crc_ok && sync_time_ok
        && sync_len_ok && sync_addr_ok && phase_byte_a <= `PHASE_MAX;

    // busy run length, and whether the closing cycle carried a sync
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_reg <= 5'h00;
            seen_reg <= 1'b0;
            had_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= (check_ack == `ACK_BUSY) ? busy_reg + 5'h01 : 5'h00;
            // a sync on the tick edge belongs to the next cycle
            seen_reg <= cycle_tick ? sync_ok : (seen_reg | sync_ok);
            had_reg <= cycle_tick ? seen_reg : had_reg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_busy_bound:
        assert property (check_ack == `ACK_BUSY |-> busy_reg <= 5'h0f)
        else $error("busy acknowledge held too long");
    a_busy_hold:
        assert property (check_ack == `ACK_BUSY && busy_reg < 5'h0f
            && check_cmd |=> check_ack == `ACK_BUSY)
        else $error("busy acknowledge ended early");
    a_busy_end:
        assert property (check_ack == `ACK_BUSY && busy_reg == 5'h0f
            && check_cmd |=> check_ack inside {`ACK_DONE, `ACK_ERROR})
        else $error("check gave no verdict after calculation");
    a_verdict_hold:
        assert property (check_ack inside {`ACK_DONE, `ACK_ERROR}
            && check_cmd |=> $stable(check_ack))
        else $error("verdict changed while command held");
    a_ack_release:
        assert property (check_ack inside {`ACK_DONE, `ACK_ERROR}
            && !check_cmd |=> check_ack == `ACK_IDLE)
        else $error("verdict not withdrawn after command cleared");
    a_busy_cause:
        assert property (check_ack == `ACK_IDLE && !check_cmd
            |=> check_ack != `ACK_BUSY)
        else $error("busy without a check command");
    a_reply_cause:
        assert property (drive_reply_telegram_stb
            |-> had_reg && $past(cycle_tick))
        else $error("reply sent in a cycle without sync");
    a_reply_due:
        assert property (cycle_tick && seen_reg
            |=> drive_reply_telegram_stb)
        else $error("reply missing after a synced cycle");
    a_phase_range:
        assert property (sync_telegram_stb |-> phase_byte_a <= `PHASE_MAX)
        else $error("master sent an out of range phase");
endmodule

/* bench/ring_slave_phase_and_fault_monitor_bench.sv */
/*
  self-checking bench: master end against one drive end, plus a second
  drive end driven directly by the bench to inject bad telegrams.
  assumes hdl/ring_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "ring_defs.svh"

module ring_slave_phase_and_fault_monitor_bench;
    typedef struct {int sel; logic [15:0] exp;} note_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] phase_req, phase1, phase2;
    logic check_start, go_phase_zero, inject_fault, tick1, tick2;
    logic params_valid, cmd_stb, ring_closed, power1, power2, shut2;
    logic err1, err2, e_err;
    logic [1:0] result1;
    logic [7:0] mask, list2;
    logic [15:0] cmd_in, cmdo2, smiss2, dmiss2, e_smiss, e_dmiss, e_cmd;
    logic [2:0] e_phase;
    int s_run, d_run, e_rep, replies;
    int miscompares = 0;
    int total_checks = 0;
    note_type notes[$];
    note_type cur;
    string names[15] = '{"phase", "shut", "err", "smiss", "dmiss", "ack",
        "list", "cmd", "reply", "phase1", "err1", "power1", "result",
        "closed", "power"};

    ring_link_if link1();
    ring_link_if link2();

    ring_master_end #(.CYCLE_CLKS(20), .CLOSE_RUN(4)) ring_master_end_i
    (
        .clk(clk), .reset_n(reset_n), .link(link1),
        .phase_req(phase_req), .check_start(check_start),
        .go_phase_zero(go_phase_zero), .inject_fault(inject_fault),
        .cycle_tick(tick1), .phase(), .ring_closed(ring_closed),
        .check_result(result1)
    );
    ring_drive_end ring_drive_end_i
    (
        .clk(clk), .reset_n(reset_n), .link(link1), .cycle_tick(tick1),
        .params_valid(params_valid), .invalid_param_mask(mask),
        .command_in(cmd_in), .command_in_stb(cmd_stb), .command_out(),
        .command_substituted(), .phase(phase1), .power_enable(power1),
        .shutdown_req(), .comm_error(err1), .invalid_param_list(),
        .sync_miss_count(), .data_miss_count()
    );
    // second drive end: its link is driven by the bench, faults included
    ring_drive_end ring_drive_end_b_i
    (
        .clk(clk), .reset_n(reset_n), .link(link2), .cycle_tick(tick2),
        .params_valid(params_valid), .invalid_param_mask(mask),
        .command_in(cmd_in), .command_in_stb(cmd_stb),
        .command_out(cmdo2), .command_substituted(), .phase(phase2),
        .power_enable(power2), .shutdown_req(shut2), .comm_error(err2),
        .invalid_param_list(list2), .sync_miss_count(smiss2),
        .data_miss_count(dmiss2)
    );
    ring_link_properties ring_link_properties_i
    (
        .clk(clk), .reset_n(reset_n), .cycle_tick(tick1),
        .sync_telegram_stb(link1.sync_telegram_stb),
        .phase_byte_a(link1.phase_byte_a), .sync_crc_ok(link1.sync_crc_ok),
        .sync_time_ok(link1.sync_time_ok), .sync_len_ok(link1.sync_len_ok),
        .sync_addr_ok(link1.sync_addr_ok), .check_cmd(link1.check_cmd),
        .check_ack(link1.check_ack),
        .drive_reply_telegram_stb(link1.drive_reply_telegram_stb)
    );

    // 25 mhz clock
    always #20 clk = ~clk;

    // count reply pulses of the fault-injection drive end
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            replies <= 0;
        else if (link2.drive_reply_telegram_stb === 1'b1)
            replies <= replies + 1;
    end

    function automatic logic [15:0] obs(int s);
        case (s)
            0: obs = {13'h0, phase2};
            1: obs = {15'h0, shut2};
            2: obs = {15'h0, err2};
            3: obs = smiss2;
            4: obs = dmiss2;
            5: obs = {14'h0, link2.check_ack};
            6: obs = {8'h00, list2};
            7: obs = cmdo2;
            8: obs = 16'(replies);
            9: obs = {13'h0, phase1};
            10: obs = {15'h0, err1};
            11: obs = {15'h0, power1};
            12: obs = {14'h0, result1};
            13: obs = {15'h0, ring_closed};
            default: obs = {15'h0, power2};
        endcase
    endfunction

    task check(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task stop_test();
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task note(int s, logic [15:0] e);
        notes.push_back('{sel: s, exp: e});
    endtask

    // notes are judged half a cycle later, once outputs have settled
    always @(negedge clk)
    begin
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            check(names[cur.sel], obs(cur.sel), cur.exp);
        end
    end

    task rst();
        // let pending notes be judged before outputs are reset
        @(posedge clk);
        reset_n <= 1'b0;
        {phase_req, check_start, go_phase_zero, inject_fault} <= 6'h00;
        {tick2, params_valid, cmd_stb, mask, cmd_in} <= 27'h0;
        {link2.sync_telegram_stb, link2.master_data_telegram_stb} <= 2'h0;
        {link2.check_cmd, link2.phase_byte_a} <= 4'h0;
        {link2.sync_crc_ok, link2.sync_time_ok} <= 2'h0;
        {link2.sync_len_ok, link2.sync_addr_ok} <= 2'h0;
        {link2.data_crc_ok, link2.data_time_ok} <= 2'h0;
        {link2.data_len_ok, link2.data_addr_ok} <= 2'h0;
        {e_phase, e_err, e_smiss, e_dmiss, e_cmd} <= 52'h0;
        {s_run, d_run, e_rep} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
    endtask

    // one communication cycle on the second link: telegrams, then tick
    task cyc(logic [3:0] q, logic [2:0] ph, logic dv, logic ss);
        logic sv;
        logic [15:0] c;
        sv = ss && q == 4'hf && ph <= `PHASE_MAX;
        c = 16'($urandom);
        @(posedge clk);
        link2.sync_telegram_stb <= ss;
        link2.phase_byte_a <= ph;
        {link2.sync_crc_ok, link2.sync_time_ok} <= q[3:2];
        {link2.sync_len_ok, link2.sync_addr_ok} <= q[1:0];
        link2.master_data_telegram_stb <= 1'b1;
        {link2.data_crc_ok, link2.data_time_ok, link2.data_len_ok,
            link2.data_addr_ok} <= dv ? 4'hf : 4'($urandom_range(0, 14));
        cmd_in <= c;
        cmd_stb <= 1'b1;
        @(posedge clk);
        {link2.sync_telegram_stb, link2.master_data_telegram_stb} <= 2'h0;
        cmd_stb <= 1'b0;
        link2.phase_byte_a <= 3'($urandom); // released byte wanders
        @(posedge clk);
        tick2 <= 1'b1;
        @(posedge clk);
        tick2 <= 1'b0;
        repeat (3) @(posedge clk);
        s_run = sv ? 0 : s_run + 1;
        d_run = dv ? 0 : d_run + 1;
        e_smiss += 16'(!sv);
        e_dmiss += 16'(!dv);
        e_rep += int'(sv);
        e_phase = sv ? ph : e_phase;
        e_cmd = dv ? c : e_cmd;
        // a lone miss is forgiven, a second one in a row is not
        if ((s_run > 1 && e_phase >= `PHASE_THREE)
            || (d_run > 1 && e_phase == `PHASE_FOUR))
        begin
            e_phase = `PHASE_ZERO;
            e_err = 1'b1;
        end
        note(0, 16'(e_phase));
        note(1, 16'(e_phase != `PHASE_FOUR));
        note(14, 16'(e_phase == `PHASE_FOUR));
        for (int s = 2; s < 9; s++)
            if (s != 5 && s != 6)
                note(s, s == 2 ? 16'(e_err) : s == 3 ? e_smiss : s == 4
                    ? e_dmiss : s == 7 ? e_cmd : 16'(e_rep));
    endtask

    task run_check(logic [1:0] e);
        @(posedge clk);
        link2.check_cmd <= 1'b1;
        @(posedge clk);
        note(5, `ACK_BUSY);
        repeat (15) @(posedge clk);
        note(5, `ACK_BUSY);
        @(posedge clk);
        note(5, e);
        link2.check_cmd <= 1'b0;
        repeat (2) @(posedge clk);
        note(5, `ACK_IDLE);
    endtask

    task wait_for(int s, logic [15:0] v);
        for (int i = 0; i < 3000 && obs(s) !== v; i++)
            @(posedge clk);
        @(posedge clk);
        note(s, v);
    endtask

    // main sequence
    initial
    begin
        void'($urandom(32'h9d717f2d));
        rst();
        link2.check_cmd <= 1'b1;
        repeat (3) @(posedge clk);
        note(5, `ACK_IDLE);
        link2.check_cmd <= 1'b0;
        cyc(4'hf, 3'h3, 1'b1, 1'b1);
        cyc(4'hf, 3'h3, 1'b0, 1'b1);
        cyc(4'hf, 3'h3, 1'b0, 1'b1);
        params_valid <= 1'b1;
        run_check(`ACK_DONE);
        params_valid <= 1'b0;
        mask <= 8'($urandom);
        run_check(`ACK_ERROR);
        note(6, {8'h00, mask});
        params_valid <= 1'b1;
        run_check(`ACK_DONE);
        cyc(4'hf, 3'h3, 1'b1, 1'b0);
        cyc(4'hf, 3'h3, 1'b1, 1'b0);
        rst();
        cyc(4'hf, 3'h4, 1'b1, 1'b1);
        for (int k = 0; k < 5; k++)
        begin
            cyc(k < 4 ? ~(4'h1 << k) : 4'hf, k < 4 ? 3'h4 : 3'h5, 1'b1, 1'b1);
            cyc(4'hf, 3'h4, 1'b1, 1'b1);
        end
        cyc(4'hf, 3'h0, 1'b1, 1'b1);
        cyc(4'hf, 3'h4, 1'b1, 1'b1);
        cyc(4'hf, 3'h4, 1'b0, 1'b1);
        cyc(4'hf, 3'h4, 1'b0, 1'b1);
        rst();
        cyc(4'hf, 3'h4, 1'b1, 1'b1);
        cyc(4'hf, 3'h4, 1'b1, 1'b0);
        cyc(4'hf, 3'h4, 1'b1, 1'b0);
        rst();
        params_valid <= 1'b1;
        phase_req <= 3'h3;
        wait_for(9, 16'h3);
        check_start <= 1'b1;
        @(posedge clk);
        check_start <= 1'b0;
        wait_for(12, `ACK_DONE);
        phase_req <= 3'h4;
        wait_for(9, 16'h4);
        note(11, 16'h1);
        go_phase_zero <= 1'b1;
        wait_for(9, 16'h0);
        repeat (100) @(posedge clk);
        note(10, 16'h0);
        inject_fault <= 1'b1;
        wait_for(13, 16'h0);
        inject_fault <= 1'b0;
        wait_for(13, 16'h1);
        repeat (2) @(posedge clk);
        stop_test();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule
